// *** rtl/adcth_pkg.sv ***
// Functional notes
// - Select one: previous takes filter output at start
// - Select zero: previous takes result at start
// - Previous follows result justification when select zero
// - Previous is 16-bit read-only, two bytes, reset zero
// - Accumulator 18-bit signed, upper bits read sign
// - Accumulator writable only while no conversion runs
// - Accumulator reached as low, high, upper byte
// - Setpoint 16-bit signed read/write, reset zero
// - Error 16-bit signed, read-only, formula by mode
// - Error against thresholds sets below/above flags
// - Threshold interrupt fires per interrupt mode field
// - Lower/upper thresholds 16-bit signed, reset zero
// - Software trigger codes: channel write, result/error reads
// - Codes for logic cells, change flag, comparator, oscillator
// - Codes for PWM, capture/compare and timers
// - Code one pin, zero disabled, top reserved
// - Port C group: eight enable bits, reset zero
// - Port A group: bits 0,1,2,4,5 only
// - Port B group: bits 4 to 7 only
// - Filter output is accumulator shifted right arithmetically
// - Averaging modes check only when count reaches setting
package adcth_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [13:0] IDX_LTH_L = 14'h1d0c;
  localparam logic [13:0] IDX_LTH_H = 14'h1d0d;
  localparam logic [13:0] IDX_UTH_L = 14'h1d0e;
  localparam logic [13:0] IDX_UTH_H = 14'h1d0f;
  localparam logic [13:0] IDX_ERR_L = 14'h1d10;
  localparam logic [13:0] IDX_ERR_H = 14'h1d11;
  localparam logic [13:0] IDX_STP_L = 14'h1d12;
  localparam logic [13:0] IDX_STP_H = 14'h1d13;
  localparam logic [13:0] IDX_FLT_L = 14'h1d14;
  localparam logic [13:0] IDX_FLT_H = 14'h1d15;
  localparam logic [13:0] IDX_ACC_L = 14'h1d16;
  localparam logic [13:0] IDX_ACC_H = 14'h1d17;
  localparam logic [13:0] IDX_ACC_U = 14'h1d18;
  localparam logic [13:0] IDX_CNT   = 14'h1d19;
  localparam logic [13:0] IDX_RPT   = 14'h1d1a;
  localparam logic [13:0] IDX_PRV_L = 14'h1d1b;
  localparam logic [13:0] IDX_PRV_H = 14'h1d1c;
  localparam logic [13:0] IDX_RES_L = 14'h1d1d;
  localparam logic [13:0] IDX_RES_H = 14'h1d1e;
  localparam logic [13:0] IDX_PCH   = 14'h1d1f;
  localparam logic [13:0] IDX_CON0  = 14'h1d26;
  localparam logic [13:0] IDX_CON2  = 14'h1d28;
  localparam logic [13:0] IDX_CON3  = 14'h1d29;
  localparam logic [13:0] IDX_STAT  = 14'h1d2a;
  localparam logic [13:0] IDX_ACT   = 14'h1d2c;
  localparam logic [13:0] IDX_CGA   = 14'h1d2e;
  localparam logic [13:0] IDX_CGB   = 14'h1d2f;
  localparam logic [13:0] IDX_CGC   = 14'h1d30;

  // Field positions.
  localparam int CON0_GO_BIT   = 0;
  localparam int CON0_FM_BIT   = 2;
  localparam int CON2_PREVIOUS_SOURCE_SELECT_BIT = 7;
  localparam int CON2_CRS_LSB  = 4;
  localparam int CON3_ERROR_MODE_A_LSB = 4;
  localparam int STAT_ABOVE_UPPER_FLAG_BIT = 6;
  localparam int STAT_BELOW_LOWER_FLAG_BIT = 5;

  // Implemented group enable bits per port.
  localparam logic [7:0] CGA_MASK = 8'h37;
  localparam logic [7:0] CGB_MASK = 8'hf0;
  localparam logic [7:0] CGC_MASK = 8'hff;

  // Reset values.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [17:0] RST_ACC  = 18'h00000;

  // Trigger source codes.
  localparam logic [5:0] TRIG_OFF     = 6'h00;
  localparam logic [5:0] TRIG_ERRH_RD = 6'h14;
  localparam logic [5:0] TRIG_RESH_RD = 6'h15;
  localparam logic [5:0] TRIG_PCH_WR  = 6'h16;
  localparam int         NUM_HW_TRIG  = 19;

  // Computation modes.
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_AVG   = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF   = 3'h4;

  // Error formulas.
  localparam logic [2:0] ERROR_MODE_A_RES_PREV = 3'h0;
  localparam logic [2:0] ERROR_MODE_A_RES_STPT = 3'h1;
  localparam logic [2:0] ERROR_MODE_A_FLT_STPT = 3'h2;

  // Threshold interrupt conditions.
  localparam logic [2:0] TMD_NEVER   = 3'h0;
  localparam logic [2:0] TMD_BELOW   = 3'h1;
  localparam logic [2:0] TMD_NBELOW  = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_NABOVE  = 3'h5;
  localparam logic [2:0] TMD_ABOVE   = 3'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ERROR_MODE_A, ST_CHECK} adcth_state_e;

endpackage

// *** rtl/adcth_trig_sel.sv ***
module adcth_trig_sel #(
  parameter int NSRC = 19
) (
  input  wire logic            ref_clk,   // System clock.
  input  wire logic            rst,       // Synchronous reset.
  input  wire logic [5:0]      trig_code, // Selected trigger source.
  input  wire logic [NSRC-1:0] src_async, // Source k answers code k+1.
  output logic                 hw_trig    // Rising edge of selected source.
);

  logic [NSRC-1:0] s1_reg;
  logic [NSRC-1:0] s2_reg;
  logic [NSRC-1:0] s3_reg;
  logic [NSRC-1:0] rise;
  logic [5:0]      sel_m1;

  // Sources may come from pins, so each passes two flops before use.
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= src_async[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
        end
      end
      assign rise[g] = s2_reg[g] & ~s3_reg[g];
    end
  endgenerate

  assign sel_m1 = trig_code - 6'h01;

  // Code zero disables; codes above the source range come from software or are reserved.
  always_comb begin
    hw_trig = 1'b0;
    if (trig_code != adcth_pkg::TRIG_OFF && trig_code <= 6'(NSRC)) begin
      hw_trig = rise[sel_m1[4:0]];
    end
  end

endmodule

// *** rtl/adcth_top.sv ***
module adcth_top (
  input  wire logic        ref_clk,     // System clock, 10 MHz.
  input  wire logic        rst,         // Synchronous reset, active high.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB enable.
  input  wire logic        pwrite,      // APB direction, high for write.
  input  wire logic [15:0] paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  input  wire logic [3:0]  pstrb,       // APB byte strobes.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error on unmapped address.
  input  wire logic [18:0] trig_src,    // Peripheral trigger sources.
  input  wire logic        conv_done,   // Sequencer: conversion finished.
  input  wire logic [9:0]  conv_result, // Sequencer: raw result.
  output logic             conv_start,  // Pulse: start a conversion.
  output logic             conv_busy,   // Conversion in progress.
  output logic      [5:0]  chan_sel,    // Selected input channel.
  output logic             thr_irq,     // Pulse: threshold interrupt.
  output logic      [7:0]  grp_en_a,    // Port A group enables.
  output logic      [7:0]  grp_en_b,    // Port B group enables.
  output logic      [7:0]  grp_en_c     // Port C group enables.
);

  adcth_pkg::adcth_state_e state_reg;

  logic [15:0] lth_reg;
  logic [15:0] uth_reg;
  logic [15:0] stpt_reg;
  logic [15:0] err_reg;
  logic [15:0] prev_reg;
  logic [15:0] res_reg;
  logic [17:0] acc_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  rpt_reg;
  logic [5:0]  pch_reg;
  logic [5:0]  act_reg;
  logic        fm_reg;
  logic        previous_source_select_reg;
  logic [2:0]  crs_reg;
  logic [2:0]  md_reg;
  logic [2:0]  error_mode_a_reg;
  logic [2:0]  tmd_reg;
  logic        above_upper_flag_reg;
  logic        below_lower_flag_reg;
  logic        go_reg;
  logic        start_reg;
  logic        irq_reg;
  logic [7:0]  cga_reg;
  logic [7:0]  cgb_reg;
  logic [7:0]  cgc_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  logic [13:0] idx;
  logic        acc_en;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        hw_trig;
  logic        sw_trig;
  logic        start;
  logic        done_now;
  logic [15:0] filt;
  logic [15:0] err_next;
  logic [15:0] res_next;
  logic        below;
  logic        above;
  logic        uses_cnt;
  logic        check_ok;
  logic        irq_cond;

  // APB: one wait state so that read data leaves a flop.
  assign idx    = paddr[15:2];
  assign acc_en = psel & penable & pready_reg;
  assign wr_en  = acc_en & pwrite & pstrb[0];
  assign rd_en  = acc_en & ~pwrite;
  assign wb     = pwdata[7:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (psel & penable & ~pready_reg) begin
      prdata_reg  <= {24'h000000, rd_byte};
      pslverr_reg <= ~rd_hit;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // Filter output follows the accumulator, low-pass mode included.
  assign filt = 16'($signed(acc_reg) >>> crs_reg);

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      adcth_pkg::IDX_LTH_L: rd_byte = lth_reg[7:0];
      adcth_pkg::IDX_LTH_H: rd_byte = lth_reg[15:8];
      adcth_pkg::IDX_UTH_L: rd_byte = uth_reg[7:0];
      adcth_pkg::IDX_UTH_H: rd_byte = uth_reg[15:8];
      adcth_pkg::IDX_ERR_L: rd_byte = err_reg[7:0];
      adcth_pkg::IDX_ERR_H: rd_byte = err_reg[15:8];
      adcth_pkg::IDX_STP_L: rd_byte = stpt_reg[7:0];
      adcth_pkg::IDX_STP_H: rd_byte = stpt_reg[15:8];
      adcth_pkg::IDX_FLT_L: rd_byte = filt[7:0];
      adcth_pkg::IDX_FLT_H: rd_byte = filt[15:8];
      adcth_pkg::IDX_ACC_L: rd_byte = acc_reg[7:0];
      adcth_pkg::IDX_ACC_H: rd_byte = acc_reg[15:8];
      adcth_pkg::IDX_ACC_U: rd_byte = {{6{acc_reg[17]}}, acc_reg[17:16]};
      adcth_pkg::IDX_CNT:   rd_byte = cnt_reg;
      adcth_pkg::IDX_RPT:   rd_byte = rpt_reg;
      adcth_pkg::IDX_PRV_L: rd_byte = prev_reg[7:0];
      adcth_pkg::IDX_PRV_H: rd_byte = prev_reg[15:8];
      adcth_pkg::IDX_RES_L: rd_byte = res_reg[7:0];
      adcth_pkg::IDX_RES_H: rd_byte = res_reg[15:8];
      adcth_pkg::IDX_PCH:   rd_byte = {2'b00, pch_reg};
      adcth_pkg::IDX_CON0:  rd_byte = {5'h00, fm_reg, 1'b0, go_reg};
      adcth_pkg::IDX_CON2:  rd_byte = {previous_source_select_reg, crs_reg, 1'b0, md_reg};
      adcth_pkg::IDX_CON3:  rd_byte = {1'b0, error_mode_a_reg, 1'b0, tmd_reg};
      adcth_pkg::IDX_STAT:  rd_byte = {1'b0, above_upper_flag_reg, below_lower_flag_reg, 5'h00};
      adcth_pkg::IDX_ACT:   rd_byte = {2'b00, act_reg};
      adcth_pkg::IDX_CGA:   rd_byte = cga_reg;
      adcth_pkg::IDX_CGB:   rd_byte = cgb_reg;
      adcth_pkg::IDX_CGC:   rd_byte = cgc_reg;
      default:              rd_hit  = 1'b0;
    endcase
  end

  // Threshold and setpoint registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lth_reg  <= adcth_pkg::RST_WORD;
      uth_reg  <= adcth_pkg::RST_WORD;
      stpt_reg <= adcth_pkg::RST_WORD;
    end else if (wr_en) begin
      case (idx)
        adcth_pkg::IDX_LTH_L: lth_reg[7:0]   <= wb;
        adcth_pkg::IDX_LTH_H: lth_reg[15:8]  <= wb;
        adcth_pkg::IDX_UTH_L: uth_reg[7:0]   <= wb;
        adcth_pkg::IDX_UTH_H: uth_reg[15:8]  <= wb;
        adcth_pkg::IDX_STP_L: stpt_reg[7:0]  <= wb;
        adcth_pkg::IDX_STP_H: stpt_reg[15:8] <= wb;
        default: ;
      endcase
    end
  end

  // Control fields.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pch_reg  <= 6'h00;
      act_reg  <= adcth_pkg::TRIG_OFF;
      fm_reg   <= 1'b0;
      previous_source_select_reg <= 1'b0;
      crs_reg  <= 3'h0;
      md_reg   <= adcth_pkg::MD_BASIC;
      error_mode_a_reg <= adcth_pkg::ERROR_MODE_A_RES_PREV;
      tmd_reg  <= adcth_pkg::TMD_NEVER;
      rpt_reg  <= adcth_pkg::RST_BYTE;
    end else if (wr_en) begin
      case (idx)
        adcth_pkg::IDX_PCH:  pch_reg <= wb[5:0];
        adcth_pkg::IDX_ACT:  act_reg <= wb[5:0];
        adcth_pkg::IDX_RPT:  rpt_reg <= wb;
        adcth_pkg::IDX_CON0: fm_reg  <= wb[adcth_pkg::CON0_FM_BIT];
        adcth_pkg::IDX_CON2: begin
          previous_source_select_reg <= wb[adcth_pkg::CON2_PREVIOUS_SOURCE_SELECT_BIT];
          crs_reg  <= wb[adcth_pkg::CON2_CRS_LSB +: 3];
          md_reg   <= wb[2:0];
        end
        adcth_pkg::IDX_CON3: begin
          error_mode_a_reg <= wb[adcth_pkg::CON3_ERROR_MODE_A_LSB +: 3];
          tmd_reg  <= wb[2:0];
        end
        default: ;
      endcase
    end
  end

  // Channel group enables; unimplemented bits never store a one.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cga_reg <= adcth_pkg::RST_BYTE;
      cgb_reg <= adcth_pkg::RST_BYTE;
      cgc_reg <= adcth_pkg::RST_BYTE;
    end else if (wr_en) begin
      case (idx)
        adcth_pkg::IDX_CGA: cga_reg <= wb & adcth_pkg::CGA_MASK;
        adcth_pkg::IDX_CGB: cgb_reg <= wb & adcth_pkg::CGB_MASK;
        adcth_pkg::IDX_CGC: cgc_reg <= wb & adcth_pkg::CGC_MASK;
        default: ;
      endcase
    end
  end

  adcth_trig_sel #(
    .NSRC (adcth_pkg::NUM_HW_TRIG)
  ) u_trig (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .trig_code (act_reg),
    .src_async (trig_src),
    .hw_trig   (hw_trig)
  );

  // Software events, including the go bit itself.
  always_comb begin
    sw_trig = wr_en && idx == adcth_pkg::IDX_CON0 && wb[adcth_pkg::CON0_GO_BIT];
    case (act_reg)
      adcth_pkg::TRIG_PCH_WR:  sw_trig = sw_trig | (wr_en && idx == adcth_pkg::IDX_PCH);
      adcth_pkg::TRIG_RESH_RD: sw_trig = sw_trig | (rd_en && idx == adcth_pkg::IDX_RES_H);
      adcth_pkg::TRIG_ERRH_RD: sw_trig = sw_trig | (rd_en && idx == adcth_pkg::IDX_ERR_H);
      default:                 sw_trig = sw_trig;
    endcase
  end

  // Triggers outside idle are dropped, so each computation completes first.
  assign start    = state_reg == adcth_pkg::ST_IDLE && (hw_trig || sw_trig);
  assign done_now = state_reg == adcth_pkg::ST_CONV && conv_done;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= adcth_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        adcth_pkg::ST_IDLE:  if (start) state_reg <= adcth_pkg::ST_CONV;
        adcth_pkg::ST_CONV:  if (conv_done) state_reg <= adcth_pkg::ST_ERROR_MODE_A;
        adcth_pkg::ST_ERROR_MODE_A:  state_reg <= adcth_pkg::ST_CHECK;
        adcth_pkg::ST_CHECK: state_reg <= adcth_pkg::ST_IDLE;
        default:             state_reg <= adcth_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      go_reg    <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= start;
      if (start) begin
        go_reg <= 1'b1;
      end else if (done_now) begin
        go_reg <= 1'b0;
      end
    end
  end

  // Captured at the start edge, before the new result lands.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_reg <= adcth_pkg::RST_WORD;
    end else if (start) begin
      prev_reg <= previous_source_select_reg ? filt : res_reg;
    end
  end

  assign res_next = fm_reg ? {6'h00, conv_result} : {conv_result, 6'h00};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_reg <= adcth_pkg::RST_WORD;
    end else if (done_now) begin
      res_reg <= res_next;
    end
  end

  // Hardware accumulation wins over a stray software write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_reg <= adcth_pkg::RST_ACC;
    end else if (done_now) begin
      if (md_reg != adcth_pkg::MD_BASIC) begin
        acc_reg <= acc_reg + 18'(res_next);
      end
    end else if (wr_en && !go_reg) begin
      case (idx)
        adcth_pkg::IDX_ACC_L: acc_reg[7:0]   <= wb;
        adcth_pkg::IDX_ACC_H: acc_reg[15:8]  <= wb;
        adcth_pkg::IDX_ACC_U: acc_reg[17:16] <= wb[1:0];
        default: ;
      endcase
    end
  end

  assign uses_cnt = md_reg == adcth_pkg::MD_AVG || md_reg == adcth_pkg::MD_BURST
                    || md_reg == adcth_pkg::MD_LPF;
  assign check_ok = !uses_cnt || cnt_reg >= rpt_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= adcth_pkg::RST_BYTE;
    end else if (done_now) begin
      if (cnt_reg != 8'hff) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end else if (wr_en && idx == adcth_pkg::IDX_CNT) begin
      cnt_reg <= wb;
    end
  end

  always_comb begin
    case (error_mode_a_reg)
      adcth_pkg::ERROR_MODE_A_RES_PREV: err_next = res_reg - prev_reg;
      adcth_pkg::ERROR_MODE_A_RES_STPT: err_next = res_reg - stpt_reg;
      adcth_pkg::ERROR_MODE_A_FLT_STPT: err_next = filt - stpt_reg;
      default:                  err_next = filt - prev_reg;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_reg <= adcth_pkg::RST_WORD;
    end else if (state_reg == adcth_pkg::ST_ERROR_MODE_A) begin
      err_reg <= err_next;
    end
  end

  assign below = $signed(err_reg) < $signed(lth_reg);
  assign above = $signed(err_reg) > $signed(uth_reg);

  always_comb begin
    case (tmd_reg)
      adcth_pkg::TMD_NEVER:   irq_cond = 1'b0;
      adcth_pkg::TMD_BELOW:   irq_cond = below;
      adcth_pkg::TMD_NBELOW:  irq_cond = !below;
      adcth_pkg::TMD_INSIDE:  irq_cond = !below && !above;
      adcth_pkg::TMD_OUTSIDE: irq_cond = below || above;
      adcth_pkg::TMD_NABOVE:  irq_cond = !above;
      adcth_pkg::TMD_ABOVE:   irq_cond = above;
      default:                irq_cond = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      below_lower_flag_reg <= 1'b0;
      above_upper_flag_reg <= 1'b0;
    end else if (state_reg == adcth_pkg::ST_CHECK && check_ok) begin
      below_lower_flag_reg <= below;
      above_upper_flag_reg <= above;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= state_reg == adcth_pkg::ST_CHECK && check_ok && irq_cond;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign conv_start = start_reg;
  assign conv_busy  = go_reg;
  assign chan_sel   = pch_reg;
  assign thr_irq    = irq_reg;
  assign grp_en_a   = cga_reg;
  assign grp_en_b   = cgb_reg;
  assign grp_en_c   = cgc_reg;

endmodule

// *** dv/adcth_monitor.sv ***
module adcth_chk (
  input wire logic       ref_clk,    // Clock.
  input wire logic       rst,        // Sync reset.
  input wire logic       psel,       // APB select.
  input wire logic       penable,    // APB enable.
  input wire logic       pready,     // APB ready.
  input wire logic       pslverr,    // APB error.
  input wire logic       conv_done,  // Conversion finished.
  input wire logic       conv_start, // Start pulse.
  input wire logic       conv_busy,  // Conversion running.
  input wire logic       thr_irq,    // Threshold interrupt.
  input wire logic [7:0] grp_en_a,   // Port A enables.
  input wire logic [7:0] grp_en_b,   // Port B enables.
  input wire logic [7:0] grp_en_c    // Port C enables.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  grp_a_mask_a: assert property ((grp_en_a & 8'hc8) == 8'h00)
    else $error("port A enable outside its bits");
  grp_b_mask_a: assert property (grp_en_b[3:0] == 4'h0)
    else $error("port B enable outside its bits");
  grp_reset_a: assert property ($fell(rst) |-> grp_en_c == 8'h00 && grp_en_a == 8'h00)
    else $error("group enables not zero after reset");
  one_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase not one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  start_busy_a: assert property (conv_start |-> conv_busy ##1 !conv_start)
    else $error("start pulse without busy or too long");
  done_idle_a: assert property (conv_done && conv_busy |=> !conv_busy [*2])
    else $error("busy held after done");
  no_restart_a: assert property (conv_busy && $past(conv_busy) |-> !conv_start)
    else $error("start while converting");
  irq_timing_a: assert property (thr_irq |-> $past(conv_done, 3) ##1 !thr_irq)
    else $error("interrupt not three cycles after done");

  start_c: cover property (conv_start);
  irq_c: cover property (thr_irq);
  err_c: cover property (pslverr);
endmodule

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [13:0] idx; logic [7:0] wd; logic [7:0] ex;} adcth_row_s;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [18:0] trig_src = 19'h00000;
  logic        conv_done = 1'b0;
  logic [9:0]  conv_result = 10'h000;
  logic        conv_start;
  logic        conv_busy;
  logic [5:0]  chan_sel;
  logic        thr_irq;
  logic [7:0]  grp_en_a;
  logic [7:0]  grp_en_b;
  logic [7:0]  grp_en_c;
  int          fails = 0;
  int          total_checks = 0;
  int          starts = 0;
  int          irqs = 0;
  int          s_exp = 0;
  int          i_exp = 0;
  int          cycles = 0;
  logic [7:0]  q;
  logic        e;
  adcth_row_s rows [13] = '{
    '{adcth_pkg::IDX_CGA, 8'hff, 8'h37}, '{adcth_pkg::IDX_CGB, 8'hff, 8'hf0},
    '{adcth_pkg::IDX_CGC, 8'ha5, 8'ha5}, '{adcth_pkg::IDX_LTH_L, 8'hfb, 8'hfb},
    '{adcth_pkg::IDX_LTH_H, 8'hff, 8'hff}, '{adcth_pkg::IDX_UTH_L, 8'h05, 8'h05},
    '{adcth_pkg::IDX_UTH_H, 8'h00, 8'h00}, '{adcth_pkg::IDX_STP_H, 8'h01, 8'h01},
    '{adcth_pkg::IDX_PRV_L, 8'h55, 8'h00}, '{adcth_pkg::IDX_ACC_U, 8'h02, 8'hfe},
    '{adcth_pkg::IDX_ACC_U, 8'h01, 8'h01}, '{adcth_pkg::IDX_ACC_L, 8'h11, 8'h11},
    '{adcth_pkg::IDX_ACT, 8'h3f, 8'h3f}};

  adcth_top adcth_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_src(trig_src), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .conv_busy(conv_busy),
    .chan_sel(chan_sel), .thr_irq(thr_irq), .grp_en_a(grp_en_a), .grp_en_b(grp_en_b),
    .grp_en_c(grp_en_c));

  always #50 ref_clk = ~ref_clk;

  // Pulses stand one cycle, so the falling edge sees each exactly once.
  always @(negedge ref_clk) begin
    if (conv_start === 1'b1) starts++;
    if (thr_irq === 1'b1) irqs++;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready is read right at the rising edge, before that edge's own updates land.
  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata[7:0];
    e = pslverr;
    if (n >= 20) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [7:0] ex, input logic [7:0] m = 8'hff);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h000000, ex}, {24'h000000, q & m});
  endtask

  task automatic conv(input logic [9:0] res, input logic st, input logic irq);
    repeat (8) @(posedge ref_clk);
    s_exp += st;
    chk("conv_start count", s_exp, starts);
    chk("conv_busy", st, conv_busy);
    if (st) begin
      conv_done <= 1'b1;
      conv_result <= res;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("conv_busy", 0, conv_busy);
    end
    i_exp += irq;
    chk("thr_irq count", i_exp, irqs);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) rdc(rows[i].idx, 8'h00);
    apb(1'b0, 14'h1d20, 8'h00);
    chk("pslverr", 1, e);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex);
    end
    chk("grp_en_a", 8'h37, grp_en_a);
    chk("grp_en_b", 8'hf0, grp_en_b);
    chk("grp_en_c", 8'ha5, grp_en_c);
    wr(adcth_pkg::IDX_ACT, 8'h00);
    wr(adcth_pkg::IDX_CON2, 8'h00);
    wr(adcth_pkg::IDX_CON3, 8'h14);
    wr(adcth_pkg::IDX_CON0, 8'h05);
    wr(adcth_pkg::IDX_ACC_L, 8'h33);
    conv(10'h10a, 1'b1, 1'b1);
    rdc(adcth_pkg::IDX_ACC_L, 8'h11);
    rdc(adcth_pkg::IDX_STAT, 8'h40, 8'h60);
    rdc(adcth_pkg::IDX_ERR_L, 8'h0a);
    rdc(adcth_pkg::IDX_ERR_H, 8'h00);
    wr(adcth_pkg::IDX_CON0, 8'h05);
    conv(10'h0fa, 1'b1, 1'b1);
    rdc(adcth_pkg::IDX_PRV_L, 8'h0a);
    rdc(adcth_pkg::IDX_PRV_H, 8'h01);
    rdc(adcth_pkg::IDX_STAT, 8'h20, 8'h60);
    for (int t = 0; t < 8; t++) begin
      wr(adcth_pkg::IDX_CON3, 8'h10 | 8'(t));
      wr(adcth_pkg::IDX_CON0, 8'h05);
      conv(10'h100, 1'b1, 1'(8'hac >> t));
    end
    wr(adcth_pkg::IDX_CON3, 8'h10);
    for (int k = 1; k < 20; k++) begin
      wr(adcth_pkg::IDX_ACT, 8'(k));
      trig_src[k-1] <= 1'b1;
      conv(10'h100, 1'b1, 1'b0);
      trig_src <= 19'h00000;
    end
    foreach (rows[k]) if (k < 3) begin
      wr(adcth_pkg::IDX_ACT, 8'h00 | ((k == 0) ? 8'h00 : 8'h17 + 8'(k * 4)));
      trig_src <= 19'h7ffff;
      conv(10'h100, 1'b0, 1'b0);
      trig_src <= 19'h00000;
    end
    wr(adcth_pkg::IDX_ACT, 8'(adcth_pkg::TRIG_PCH_WR));
    wr(adcth_pkg::IDX_PCH, 8'h05);
    conv(10'h100, 1'b1, 1'b0);
    chk("chan_sel", 6'h05, chan_sel);
    wr(adcth_pkg::IDX_ACT, 8'(adcth_pkg::TRIG_RESH_RD));
    rdc(adcth_pkg::IDX_RES_H, 8'h01);
    conv(10'h100, 1'b1, 1'b0);
    wr(adcth_pkg::IDX_ACT, 8'(adcth_pkg::TRIG_ERRH_RD));
    rdc(adcth_pkg::IDX_ERR_H, 8'h00);
    conv(10'h100, 1'b1, 1'b0);
    // Accumulator now 0x10011: shift one, accumulate mode, previous from filter.
    wr(adcth_pkg::IDX_CON2, 8'h91);
    rdc(adcth_pkg::IDX_FLT_L, 8'h08);
    rdc(adcth_pkg::IDX_FLT_H, 8'h80);
    wr(adcth_pkg::IDX_CON0, 8'h05);
    conv(10'h100, 1'b1, 1'b0);
    rdc(adcth_pkg::IDX_PRV_L, 8'h08);
    rdc(adcth_pkg::IDX_PRV_H, 8'h80);
    rdc(adcth_pkg::IDX_ACC_H, 8'h01);
    // Average mode, interrupt always: only the second run reaches the repeat setting.
    wr(adcth_pkg::IDX_CON2, 8'h02);
    wr(adcth_pkg::IDX_CON3, 8'h17);
    wr(adcth_pkg::IDX_RPT, 8'h02);
    wr(adcth_pkg::IDX_CNT, 8'h00);
    for (int r = 0; r < 2; r++) begin
      wr(adcth_pkg::IDX_CON0, 8'h05);
      conv(10'h100, 1'b1, 1'(r));
    end
    tally_and_finish();
  end
endmodule

bind adcth_top adcth_chk adcth_chk_inst (.ref_clk, .rst, .psel, .penable, .pready, .pslverr,
  .conv_done, .conv_start, .conv_busy, .thr_irq, .grp_en_a, .grp_en_b, .grp_en_c);
